// ==== hdl/rst_seq_pkg.sv ====
// constants for the reset sequencer: machine cycle timing and reset defaults
// assumes one oscillator-rate clock drives the whole sequencer
package rst_seq_pkg;
  // ============================================================
  // machine cycle timing
  localparam int unsigned STATES_PER_CYCLE = 6;
  localparam int unsigned PHASES_PER_STATE = 2;
  localparam logic [3:0]  TICK_LAST        = 4'hb;  // twelve ticks per machine cycle
  localparam logic [3:0]  TICK_S5P1        = 4'h8;  // state 5 phase 1
  localparam logic [3:0]  TICK_S5P2        = 4'h9;  // state 5 phase 2
  localparam logic [1:0]  MIN_RESET_CYCLES = 2'h2;
  // ============================================================
  // reset defaults
  localparam logic [15:0] PC_RESET         = 16'h0000;
  localparam logic [7:0]  SP_RESET         = 8'h07;
  localparam logic [7:0]  PORT_RESET       = 8'hff;
  localparam logic [2:0]  PSEL_RESET       = 3'h0;
  localparam int unsigned NUM_PORTS        = 7;
endpackage : rst_seq_pkg

// ==== hdl/reset_sync_and_reset_output.sv ====
// reset sampling, internal reset, merged reset output and bus restart timing
// assumes clk_sys is the oscillator (or the auxiliary clock the oscillator
// watchdog substitutes); wdt and osc-watchdog requests are synchronous pulses/levels
`timescale 1ns/1ps
`default_nettype none

module reset_sync_and_reset_output
  import rst_seq_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic                    reset_pin_n,
  input  wire logic                    wdt_reset_req,
  input  wire logic                    oscwd_reset_req,
  input  wire logic                    external_program_select_n,
  output logic                         reset_out_n,
  output logic                         internal_reset,
  output logic                         addr_drive,
  output logic                         ale,
  output logic [15:0]                  pc_value,
  output logic [7:0]                   sp_value,
  output logic [rst_seq_pkg::NUM_PORTS*8-1:0] port_latches,
  output logic [2:0]                   pointer_select_field,
  output logic [3:0]                   phase_tick
);
  import rst_seq_pkg::*;

  typedef enum logic [1:0] {
    RUN,
    RESETTING,
    RESTART
  } seq_e;

  typedef struct packed {
    logic [3:0]                 tick;
    logic                       ext_sync;     // synchronised external request, high = active
    logic [1:0]                 low_cnt;
    logic [1:0]                 int_cnt;      // remaining internal watchdog hold cycles
    logic                       int_req;
    seq_e                       state;
    logic                       int_rst;
    logic                       rst_out_n;
    logic                       addr_on;
    logic                       ale;
    logic [15:0]                pc;
    logic [7:0]                 sp;
    logic [NUM_PORTS*8-1:0]     ports;
    logic [2:0]                 psel;
  } state_s;

  state_s q;
  state_s d;

  // state 5 phase 2 strobe decoded once, used for sampling and release
  function automatic logic is_tick(input logic [3:0] t, input logic [3:0] at);
    is_tick = (t == at);
  endfunction : is_tick

  // ============================================================
  // next state
  always_comb begin
    logic s5p2;
    logic s5p1;
    logic any_req;
    s5p2    = 1'b0;
    s5p1    = 1'b0;
    any_req = 1'b0;
    d       = q;
    // a stopped clock simply stops this sequencer, so only the asynchronous rstn resets without one
    d.tick = (q.tick == TICK_LAST) ? 4'h0 : q.tick + 4'h1;
    s5p1   = is_tick(q.tick, TICK_S5P1);
    s5p2   = is_tick(q.tick, TICK_S5P2);

    if (s5p2) begin
      d.ext_sync = ~reset_pin_n;
      if (~reset_pin_n) begin
        if (q.low_cnt != MIN_RESET_CYCLES) begin
          d.low_cnt = q.low_cnt + 2'h1;
        end
      end else begin
        d.low_cnt = 2'h0;
      end
    end

    // internal requests are stretched to whole machine cycles; the request drops only at the
    // third sample point so that even a request raised just before one lasts two full cycles
    if (wdt_reset_req || oscwd_reset_req) begin
      d.int_req = 1'b1;
      d.int_cnt = MIN_RESET_CYCLES;
    end else if (s5p2 && q.int_req) begin
      if (q.int_cnt == 2'h0) begin
        d.int_req = 1'b0;
      end else begin
        d.int_cnt = q.int_cnt - 2'h1;
      end
    end

    any_req       = d.ext_sync | d.int_req;
    d.rst_out_n   = ~any_req;
    d.ale         = q.ale;

    unique case (q.state)
      RUN: begin
        d.ale = (q.tick == TICK_S5P1) || (q.tick == 4'h2) ? 1'b1 : (s5p2 ? 1'b0 : q.ale);
        if (q.int_req || (s5p2 && ~reset_pin_n)) begin
          d.state = RESETTING;
        end
      end
      RESETTING: begin
        d.addr_on = 1'b0;
        d.ale     = 1'b0;
        // second low-sampled cycle onward, or any held internal request
        if ((q.low_cnt == MIN_RESET_CYCLES) || q.int_req) begin
          d.int_rst = 1'b1;
        end
        // leave together with the output release so internal_reset never outlasts reset_out_n
        if (s5p2 && reset_pin_n && ~d.int_req) begin
          d.state   = RESTART;
          d.int_rst = 1'b0;
        end
      end
      RESTART: begin
        if (q.int_req || (s5p2 && ~reset_pin_n)) begin
          d.state = RESETTING;
        end else if (s5p1) begin
          d.addr_on = ~external_program_select_n;
          d.ale     = 1'b1;
        end else if (s5p2) begin
          d.ale   = 1'b0;
          d.state = RUN;
        end
      end
    endcase

    // register defaults forced while internal reset is applied; ram is outside this block
    if (q.int_rst) begin
      d.pc    = PC_RESET;
      d.sp    = SP_RESET;
      d.ports = {NUM_PORTS{PORT_RESET}};
      d.psel  = PSEL_RESET;
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q.tick      <= 4'h0;
      q.ext_sync  <= 1'b0;
      q.low_cnt   <= 2'h0;
      q.int_cnt   <= 2'h0;
      q.int_req   <= 1'b0;
      q.state     <= RUN;
      q.int_rst   <= 1'b0;
      q.rst_out_n <= 1'b1;
      q.addr_on   <= 1'b0;
      q.ale       <= 1'b0;
      q.pc        <= PC_RESET;
      q.sp        <= SP_RESET;
      q.ports     <= {NUM_PORTS{PORT_RESET}};
      q.psel      <= PSEL_RESET;
    end else begin
      q <= d;
    end
  end

  assign reset_out_n          = q.rst_out_n;
  assign internal_reset       = q.int_rst;
  assign addr_drive           = q.addr_on;
  assign ale                  = q.ale;
  assign pc_value             = q.pc;
  assign sp_value             = q.sp;
  assign port_latches         = q.ports;
  assign pointer_select_field = q.psel;
  assign phase_tick           = q.tick;

endmodule : reset_sync_and_reset_output

`default_nettype wire

// ==== test/reset_src_model.sv ====
// external reset source driving the reset pin low for a commanded number of clocks
// assumes go is a one-clock pulse; the pin idles high through its pull-up
`timescale 1ns/1ps
`default_nettype none
module reset_src_model (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            reset_pin_n
);
  logic [7:0] cnt_q = 8'h00;
  // callers ask for 24 clocks or more, except a glitch that is meant to be ignored
  always @(posedge clk_sys) begin
    if (go) cnt_q <= len;
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
  assign reset_pin_n = (cnt_q == 8'h00);
endmodule : reset_src_model
`default_nettype wire

// ==== test/reset_sync_and_reset_output_chk.sv ====
// timing checks for the reset sequencer
// assumes the sequencer package is compiled first; bound to the sequencer module
`timescale 1ns/1ps
`default_nettype none
module reset_sync_and_reset_output_chk
  import rst_seq_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       reset_pin_n,
  input wire logic       wdt_reset_req,
  input wire logic       oscwd_reset_req,
  input wire logic       reset_out_n,
  input wire logic       internal_reset,
  input wire logic       addr_drive,
  input wire logic       ale,
  input wire logic [3:0] phase_tick
);
  // ======
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_tick_wrap: assert property (phase_tick == TICK_LAST |=> phase_tick == 4'h0) else $error("no wrap");
  a_tick_step: assert property (phase_tick != TICK_LAST |=> phase_tick == $past(phase_tick) + 4'h1)
    else $error("tick skipped");
  a_pin_sampled: assert property ($fell(reset_out_n) && !$past(wdt_reset_req) && !$past(oscwd_reset_req)
    |-> $past(phase_tick) == TICK_S5P2) else $error("pin taken off sample point");
  a_low_sample: assert property (phase_tick == TICK_S5P2 && !reset_pin_n |=> !reset_out_n)
    else $error("low sample lost");
  a_req_out: assert property (wdt_reset_req || oscwd_reset_req |=> !reset_out_n) else $error("request lost");
  a_min_low: assert property ($fell(reset_out_n) |=> !reset_out_n [*8]) else $error("output too short");
  a_release_point: assert property ($rose(reset_out_n) |-> $past(phase_tick) == TICK_S5P2)
    else $error("release off sample point");
  a_first_ale: assert property ($rose(addr_drive) |-> phase_tick == TICK_S5P2 ##1 $fell(ale))
    else $error("strobe misplaced");
endmodule : reset_sync_and_reset_output_chk
bind reset_sync_and_reset_output reset_sync_and_reset_output_chk i_chk (.clk_sys(clk_sys), .rstn(rstn),
  .reset_pin_n(reset_pin_n), .wdt_reset_req(wdt_reset_req), .oscwd_reset_req(oscwd_reset_req),
  .reset_out_n(reset_out_n), .internal_reset(internal_reset), .addr_drive(addr_drive), .ale(ale),
  .phase_tick(phase_tick));
`default_nettype wire

// ==== test/reset_sync_and_reset_output_bench.sv ====
// self-checking bench for the reset sequencer
// assumes package, design, checker and reset source model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module reset_sync_and_reset_output_bench;
  import rst_seq_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, wdt = 1'b0, oscwd = 1'b0, esn = 1'b0, go = 1'b0;
  logic [7:0] len = 8'h00, sp;
  logic pin_n, out_n, ireset, addr, ale;
  logic [15:0] pc;
  logic [NUM_PORTS*8-1:0] ports;
  logic [2:0] psel;
  logic [3:0] tick;
  int num_errors = 0, checks = 0;
  // ======
  // rows: expected address drive, program select, source (pin, watchdog, osc watchdog)
  logic [3:0] rows [4] = '{4'h8, 4'h4, 4'h9, 4'ha};
  always #12.5 clk_sys = ~clk_sys;
  reset_src_model i_reset_src_model (.clk_sys(clk_sys), .go(go), .len(len), .reset_pin_n(pin_n));
  reset_sync_and_reset_output i_reset_sync_and_reset_output (.clk_sys(clk_sys), .rstn(rstn), .reset_pin_n(pin_n),
    .wdt_reset_req(wdt), .oscwd_reset_req(oscwd), .external_program_select_n(esn), .reset_out_n(out_n),
    .internal_reset(ireset), .addr_drive(addr), .ale(ale), .pc_value(pc), .sp_value(sp), .port_latches(ports),
    .pointer_select_field(psel), .phase_tick(tick));
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic pulse(input logic [2:0] src, input logic [7:0] n, input logic e);
    @(posedge clk_sys);
    {oscwd, wdt, go} <= src;
    len <= n;
    esn <= e;
    @(posedge clk_sys);
    {oscwd, wdt, go} <= 3'h0;
  endtask : pulse
  initial begin
    #50000 num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      pulse(3'h1 << rows[i][1:0], 8'd30, rows[i][2]);
      for (int n = 0; n < 20 && out_n !== 1'b0; n++) @(negedge clk_sys);
      `CHK(out_n, 1'b0)
      for (int n = 0; n < 40 && ireset !== 1'b1; n++) @(negedge clk_sys);
      @(negedge clk_sys);
      `CHK({pc, sp, ports, psel}, {16'h0000, 8'h07, {NUM_PORTS{8'hff}}, 3'h0})
      for (int n = 0; n < 60 && out_n !== 1'b1; n++) @(negedge clk_sys);
      `CHK({tick, ireset}, 5'h14)
      for (int n = 0; n < 14 && tick !== 4'h9; n++) @(negedge clk_sys);
      `CHK({addr, ale}, {rows[i][3], 1'b1})
      @(negedge clk_sys);
      `CHK(ale, 1'b0)
    end
    pulse(3'h1, 8'd150, 1'b0);
    repeat (120) @(negedge clk_sys);
    `CHK({out_n, ireset}, 2'b01)
    for (int n = 0; n < 60 && out_n !== 1'b1; n++) @(negedge clk_sys);
    for (int n = 0; n < 14 && tick !== 4'h0; n++) @(negedge clk_sys);
    // a short dip clear of the sample point must go unseen
    pulse(3'h1, 8'd3, 1'b0);
    repeat (24) @(negedge clk_sys);
    `CHK(out_n, 1'b1)
    report_and_stop();
  end
endmodule : reset_sync_and_reset_output_bench
`default_nettype wire
